// *** src/fifo_pkg.sv ***
// Shared constants for the FIFO device end and its host controller
package fifo_pkg;
  localparam int DATA_W       = 18;
  localparam int DEPTH        = 8192;
  localparam int OFFSET_W     = 14;
  localparam logic [13:0] OFFSET_DEFAULT = 14'h007f;
  localparam int CLK_PERIOD_NS = 8;
  // Recovery time after a retransmit pulse; value not given, plain default
  localparam int RETRANSMIT_RECOVERY_NS = 10;
  localparam int RTR_CYCLES_RAW =
    (RETRANSMIT_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RTR_CYCLES = (RTR_CYCLES_RAW < 1) ? 1 : RTR_CYCLES_RAW;
  // Host register byte offsets
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h8;
  // Command bits in REG_CMD
  localparam int CMD_WRITE      = 0;
  localparam int CMD_READ       = 1;
  localparam int CMD_OFS_WRITE  = 2;
  localparam int CMD_OFS_READ   = 3;
  localparam int CMD_RETRANSMIT = 4;
  // Status bit positions in REG_CMD read value
  localparam int ST_EMPTY_N  = 0;
  localparam int ST_AEMPTY_N = 1;
  localparam int ST_HALF_N   = 2;
  localparam int ST_AFULL_N  = 3;
  localparam int ST_FULL_N   = 4;
  localparam int ST_BUSY     = 5;
  localparam int ST_RVALID   = 6;
endpackage : fifo_pkg

// *** src/fifo_link_if.sv ***
// Link between the FIFO device and its host controller
`timescale 1ns/1ps
interface fifo_link_if;
  logic [17:0] wdata;
  logic        wen_n;
  logic        ren_n;
  logic        offset_load_n;
  logic        retransmit_pulse;
  logic        first_device_select_n;
  logic        write_chain_in_n;
  logic        read_chain_in_n;
  logic [17:0] rdata;
  logic        empty_ind_n;
  logic        almost_empty_ind_n;
  logic        half_full_ind_n;
  logic        almost_full_ind_n;
  logic        full_ind_n;
  logic        write_chain_out_n;
  logic        read_chain_out_n;

  modport device (
    input  wdata, wen_n, ren_n, offset_load_n, retransmit_pulse,
           first_device_select_n, write_chain_in_n, read_chain_in_n,
    output rdata, empty_ind_n, almost_empty_ind_n, half_full_ind_n,
           almost_full_ind_n, full_ind_n, write_chain_out_n, read_chain_out_n
  );
  modport host (
    output wdata, wen_n, ren_n, offset_load_n, retransmit_pulse,
           first_device_select_n, write_chain_in_n, read_chain_in_n,
    input  rdata, empty_ind_n, almost_empty_ind_n, half_full_ind_n,
           almost_full_ind_n, full_ind_n, write_chain_out_n, read_chain_out_n
  );
endinterface : fifo_link_if

// *** src/fifo_store.sv ***
// Storage array with one write port and one asynchronous read port
`timescale 1ns/1ps
module fifo_store #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8192
) (
  // Clock
  input  wire logic                     clk_i,
  // Write port
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [WIDTH-1:0]         rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Contents need no reset; flags keep stale words from being read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];
endmodule : fifo_store

// *** src/fifo_device.sv ***
// FIFO device end: storage, pointers, flags, offsets, retransmit, cascade
`timescale 1ns/1ps
module fifo_device #(
  parameter int DATA_W   = fifo_pkg::DATA_W,
  parameter int DEPTH    = fifo_pkg::DEPTH,
  parameter int OFFSET_W = fifo_pkg::OFFSET_W
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Configuration
  input  wire logic depth_cascade_i,
  // Link
  fifo_link_if.device link
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  initial begin
    if (DEPTH < 4 || DATA_W < OFFSET_W || OFFSET_W < 1 || (1 << AW) != DEPTH) begin
      $error("fifo_device: unsupported DEPTH or widths");
    end
  end

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == LAST) ? '0 : p + 1'b1;
  endfunction : ptr_next

  logic [AW-1:0]       wr_ptr_q;
  logic [AW-1:0]       rd_ptr_q;
  logic [CW-1:0]       count_q;
  logic [CW-1:0]       count_d;
  logic [CW-1:0]       written_q;
  logic [OFFSET_W-1:0] empty_off_q;
  logic [OFFSET_W-1:0] full_off_q;
  logic                wsel_full_q;
  logic                rsel_full_q;
  logic                init_q;
  logic                wr_tok_q;
  logic                rd_tok_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                empty_n_q;
  logic                aempty_n_q;
  logic                half_n_q;
  logic                afull_n_q;
  logic                full_n_q;
  logic                wchain_n_q;
  logic                rchain_n_q;
  logic [DATA_W-1:0]   mem_rdata;
  logic                wr_do;
  logic                rd_do;
  logic                ofs_wr;
  logic                ofs_rd;
  logic                rt_do;

  // A depth-cascaded part only writes or reads data while it holds the chain token
  assign ofs_wr = !link.offset_load_n && !link.wen_n;
  assign ofs_rd = !link.offset_load_n && !link.ren_n;
  assign wr_do  = link.offset_load_n && !link.wen_n && full_n_q
                  && (!depth_cascade_i || wr_tok_q);
  assign rd_do  = link.offset_load_n && !link.ren_n && empty_n_q
                  && (!depth_cascade_i || rd_tok_q);
  assign rt_do  = link.retransmit_pulse && !depth_cascade_i;

  fifo_store #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_store (
    .clk_i   (clk_i),
    .we_i    (wr_do),
    .waddr_i (wr_ptr_q),
    .wdata_i (link.wdata),
    .raddr_i (rd_ptr_q),
    .rdata_o (mem_rdata)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
    end else if (wr_do) begin
      wr_ptr_q <= ptr_next(wr_ptr_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ptr_q <= '0;
    end else if (rt_do) begin
      rd_ptr_q <= '0;
    end else if (rd_do) begin
      rd_ptr_q <= ptr_next(rd_ptr_q);
    end
  end

  // Words written since reset, saturating at depth, so a retransmit
  // can rebuild the count; past depth the replay start is overwritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      written_q <= '0;
    end else if (wr_do && written_q != CW'(DEPTH)) begin
      written_q <= written_q + 1'b1;
    end
  end

  always_comb begin
    if (rt_do) begin
      count_d = written_q;
    end else begin
      count_d = count_q + CW'(wr_do) - CW'(rd_do);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Flags registered from the next count so they track it exactly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      empty_n_q  <= 1'b0;
      aempty_n_q <= 1'b0;
      half_n_q   <= 1'b1;
      afull_n_q  <= 1'b1;
      full_n_q   <= 1'b1;
    end else begin
      empty_n_q  <= (count_d != '0);
      aempty_n_q <= (32'(count_d) > 32'(empty_off_q));
      half_n_q   <= depth_cascade_i || (32'(count_d) <= DEPTH / 2);
      afull_n_q  <= (32'(count_d) + 32'(full_off_q) < DEPTH);
      full_n_q   <= (count_d != CW'(DEPTH));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      empty_off_q <= OFFSET_W'(fifo_pkg::OFFSET_DEFAULT);
      full_off_q  <= OFFSET_W'(fifo_pkg::OFFSET_DEFAULT);
      wsel_full_q <= 1'b0;
    end else if (ofs_wr) begin
      if (wsel_full_q) begin
        full_off_q <= link.wdata[OFFSET_W-1:0];
      end else begin
        empty_off_q <= link.wdata[OFFSET_W-1:0];
      end
      wsel_full_q <= !wsel_full_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsel_full_q <= 1'b0;
    end else if (ofs_rd) begin
      rsel_full_q <= !rsel_full_q;
    end
  end

  // Output word holds the last valid read while empty, except that an offset read loads the selected offset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (ofs_rd) begin
      rdata_q <= DATA_W'(rsel_full_q ? full_off_q : empty_off_q);
    end else if (rd_do) begin
      rdata_q <= mem_rdata;
    end
  end

  // Strap sampled one cycle after reset release, never under reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_tok_q   <= 1'b0;
      wchain_n_q <= 1'b1;
    end else begin
      wchain_n_q <= 1'b1;
      if (init_q) begin
        wr_tok_q <= !link.first_device_select_n;
      end else if (depth_cascade_i && wr_do && wr_ptr_q == LAST) begin
        wr_tok_q   <= 1'b0;
        wchain_n_q <= 1'b0;
      end else if (!link.write_chain_in_n) begin
        wr_tok_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_tok_q   <= 1'b0;
      rchain_n_q <= 1'b1;
    end else begin
      rchain_n_q <= 1'b1;
      if (init_q) begin
        rd_tok_q <= !link.first_device_select_n;
      end else if (depth_cascade_i && rd_do && rd_ptr_q == LAST) begin
        rd_tok_q   <= 1'b0;
        rchain_n_q <= 1'b0;
      end else if (!link.read_chain_in_n) begin
        rd_tok_q <= 1'b1;
      end
    end
  end

  assign link.rdata              = rdata_q;
  assign link.empty_ind_n        = empty_n_q;
  assign link.almost_empty_ind_n = aempty_n_q;
  assign link.half_full_ind_n    = half_n_q;
  assign link.almost_full_ind_n  = afull_n_q;
  assign link.full_ind_n         = full_n_q;
  assign link.write_chain_out_n  = wchain_n_q;
  assign link.read_chain_out_n   = rchain_n_q;
endmodule : fifo_device

// *** src/fifo_host.sv ***
// Host controller: Wishbone registers driving the FIFO link
`timescale 1ns/1ps
module fifo_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Link
  fifo_link_if.host link
);
  localparam int RTR_W = $clog2(fifo_pkg::RTR_CYCLES + 2);

  logic [17:0]      wdata_q;
  logic [17:0]      rdata_q;
  logic             rvalid_q;
  logic             wen_n_q;
  logic             ren_n_q;
  logic             load_n_q;
  logic             rt_q;
  logic             capture_q;
  logic [RTR_W-1:0] hold_q;
  logic [31:0]      dat_q;
  logic             ack_q;
  logic             req;
  logic             busy;
  logic [4:0]       cmd;

  assign req  = cyc_i && stb_i && !ack_q;
  assign busy = (hold_q != '0) || rt_q || !wen_n_q || !ren_n_q;
  assign cmd  = (req && we_i && adr_i == fifo_pkg::REG_CMD && sel_i[0] && !busy)
                ? dat_i[4:0] : 5'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req && !we_i) begin
        if (adr_i == fifo_pkg::REG_CMD) begin
          dat_q <= {25'h0000000, rvalid_q, busy, link.full_ind_n,
                    link.almost_full_ind_n, link.half_full_ind_n,
                    link.almost_empty_ind_n, link.empty_ind_n};
        end else if (adr_i == fifo_pkg::REG_WDATA) begin
          dat_q <= {14'h0000, wdata_q};
        end else if (adr_i == fifo_pkg::REG_RDATA) begin
          dat_q <= {14'h0000, rdata_q};
        end else begin
          dat_q <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdata_q <= '0;
    end else if (req && we_i && adr_i == fifo_pkg::REG_WDATA) begin
      if (sel_i[0]) wdata_q[7:0]   <= dat_i[7:0];
      if (sel_i[1]) wdata_q[15:8]  <= dat_i[15:8];
      if (sel_i[2]) wdata_q[17:16] <= dat_i[17:16];
    end
  end

  // One-cycle strobes; retransmit wins and blocks the write and read enables, not the offset load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wen_n_q  <= 1'b1;
      ren_n_q  <= 1'b1;
      load_n_q <= 1'b1;
      rt_q     <= 1'b0;
    end else begin
      rt_q     <= cmd[fifo_pkg::CMD_RETRANSMIT];
      wen_n_q  <= !((cmd[fifo_pkg::CMD_WRITE] || cmd[fifo_pkg::CMD_OFS_WRITE])
                    && !cmd[fifo_pkg::CMD_RETRANSMIT]);
      ren_n_q  <= !((cmd[fifo_pkg::CMD_READ] || cmd[fifo_pkg::CMD_OFS_READ])
                    && !cmd[fifo_pkg::CMD_RETRANSMIT]);
      load_n_q <= !(cmd[fifo_pkg::CMD_OFS_WRITE] || cmd[fifo_pkg::CMD_OFS_READ]);
    end
  end

  // Recovery hold after the retransmit pulse keeps the link quiet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= '0;
    end else if (rt_q) begin
      hold_q <= RTR_W'(fifo_pkg::RTR_CYCLES);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  // Read data lands one cycle after the strobe; taken even if empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_q <= 1'b0;
      rdata_q   <= '0;
      rvalid_q  <= 1'b0;
    end else begin
      capture_q <= !ren_n_q;
      if (capture_q) begin
        rdata_q  <= link.rdata;
        rvalid_q <= 1'b1;
      end else if (req && !we_i && adr_i == fifo_pkg::REG_RDATA) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign dat_o                      = dat_q;
  assign ack_o                      = ack_q;
  assign link.wdata                 = wdata_q;
  assign link.wen_n                 = wen_n_q;
  assign link.ren_n                 = ren_n_q;
  assign link.offset_load_n         = load_n_q;
  assign link.retransmit_pulse      = rt_q;
  assign link.first_device_select_n = 1'b0;
  // A lone part closes its own chain ring, so tokens come back
  assign link.write_chain_in_n      = link.write_chain_out_n;
  assign link.read_chain_in_n       = link.read_chain_out_n;
endmodule : fifo_host

// *** verification/fifo_link_checker.sv ***
// Link properties between the FIFO device and its host
`timescale 1ns/1ps
module fifo_link_checker (
  // Clock, reset and mode
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        depth_cascade_i,
  // Link signals
  input wire logic        wen_n,
  input wire logic        ren_n,
  input wire logic        offset_load_n,
  input wire logic        retransmit_pulse,
  input wire logic [17:0] rdata,
  input wire logic        empty_ind_n,
  input wire logic        almost_empty_ind_n,
  input wire logic        half_full_ind_n,
  input wire logic        almost_full_ind_n,
  input wire logic        full_ind_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_full_block;
    !full_ind_n && !wen_n && offset_load_n && ren_n && !retransmit_pulse |=> !full_ind_n;
  endproperty
  a_full_block: assert property (p_full_block) else $error("write taken while full");
  property p_empty_block;
    !empty_ind_n && !ren_n && offset_load_n && wen_n && !retransmit_pulse
      |=> !empty_ind_n && $stable(rdata);
  endproperty
  a_empty_block: assert property (p_empty_block) else $error("read taken while empty");
  property p_empty_ae;
    !empty_ind_n |-> !almost_empty_ind_n;
  endproperty
  a_empty_ae: assert property (p_empty_ae) else $error("almost empty high at zero");
  property p_full_af;
    !full_ind_n |-> !almost_full_ind_n && (depth_cascade_i || !half_full_ind_n);
  endproperty
  a_full_af: assert property (p_full_af) else $error("full without lower flags");
  property p_first_word;
    !empty_ind_n && !wen_n && offset_load_n && ren_n && !retransmit_pulse && !depth_cascade_i
      |=> empty_ind_n;
  endproperty
  a_first_word: assert property (p_first_word) else $error("empty stuck after write");
  property p_rdata_hold;
    ren_n |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("output word moved");
  property p_no_half;
    depth_cascade_i && $past(depth_cascade_i) |-> half_full_ind_n;
  endproperty
  a_no_half: assert property (p_no_half) else $error("half full shown in cascade");
  property p_rt_cascade;
    retransmit_pulse && depth_cascade_i && wen_n && ren_n
      |=> $stable(empty_ind_n) && $stable(full_ind_n);
  endproperty
  a_rt_cascade: assert property (p_rt_cascade) else $error("retransmit acted in cascade");
  // Host must keep the link quiet through recovery
  property p_rt_quiet;
    retransmit_pulse |-> wen_n && ren_n ##1 (wen_n && ren_n)[*2];
  endproperty
  a_rt_quiet: assert property (p_rt_quiet) else $error("access near retransmit");
  c_full: cover property (!full_ind_n);
  c_rt: cover property (retransmit_pulse);
  c_ofs_rd: cover property (!offset_load_n && !ren_n);
endmodule : fifo_link_checker

// *** verification/tb_top.sv ***
// Bench: Wishbone command sequences through the host into the FIFO device
`timescale 1ns/1ps
module tb_top;
  // Small depth keeps fills short; default offsets still fit
  localparam int D = 256;
  logic        clk_i;
  logic        rst_i;
  logic        cascade;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] s;
  int          failures;
  int          samples_checked;
  int          cnt;
  int          wrote;
  int          n;
  int          m;
  fifo_link_if link();
  fifo_device #(.DEPTH(D)) fifo_device_inst (.clk_i(clk_i), .rst_i(rst_i),
    .depth_cascade_i(cascade), .link(link));
  fifo_host fifo_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .link(link));
  fifo_link_checker fifo_link_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .depth_cascade_i(cascade), .wen_n(link.wen_n), .ren_n(link.ren_n),
    .offset_load_n(link.offset_load_n), .retransmit_pulse(link.retransmit_pulse),
    .rdata(link.rdata), .empty_ind_n(link.empty_ind_n),
    .almost_empty_ind_n(link.almost_empty_ind_n), .half_full_ind_n(link.half_full_ind_n),
    .almost_full_ind_n(link.almost_full_ind_n), .full_ind_n(link.full_ind_n));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [17:0] pat(input int i);
    return 18'h2a5a5 ^ 18'(i * 7);
  endfunction : pat

  function automatic logic [5:0] st(input int c);
    return {1'b0, c != D, c < D - m, (c <= D / 2) || (cascade === 1'b1), c > n, c != 0};
  endfunction : st

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      failures++;
      finish_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Command, then poll status until the host is idle again
  task automatic cmd(input int b, input logic [17:0] d);
    int k;
    logic [31:0] q;
    wb(1'b1, fifo_pkg::REG_WDATA, {14'h0000, d}, q);
    wb(1'b1, fifo_pkg::REG_CMD, 32'h1 << b, q);
    k = 0;
    do begin
      wb(1'b0, fifo_pkg::REG_CMD, 32'h0, s);
      k++;
    end while (s[fifo_pkg::ST_BUSY] !== 1'b0 && k < 50);
    if (s[fifo_pkg::ST_BUSY] !== 1'b0) begin
      failures++;
      finish_test();
    end
  endtask : cmd

  task automatic put(input int i);
    cmd(fifo_pkg::CMD_WRITE, pat(i));
    if (cnt < D) begin
      cnt++;
      wrote++;
    end
    chk(32'(s[5:0]), 32'(st(cnt)));
  endtask : put

  task automatic get(input int i);
    logic [31:0] q;
    cmd(fifo_pkg::CMD_READ, 18'h00000);
    if (cnt > 0) begin
      cnt--;
    end
    chk(32'(s[5:0]), 32'(st(cnt)));
    wb(1'b0, fifo_pkg::REG_RDATA, 32'h0, q);
    chk(32'(q[17:0]), 32'(pat(i)));
  endtask : get

  task automatic rt();
    cmd(fifo_pkg::CMD_RETRANSMIT, 18'h00000);
    if (cascade !== 1'b1) begin
      cnt = (wrote < D) ? wrote : D;
    end
    chk(32'(s[5:0]), 32'(st(cnt)));
  endtask : rt

  task automatic ofs_rd(input logic [13:0] e);
    logic [31:0] q;
    cmd(fifo_pkg::CMD_OFS_READ, 18'h00000);
    wb(1'b0, fifo_pkg::REG_RDATA, 32'h0, q);
    chk(32'(q[13:0]), 32'(e));
  endtask : ofs_rd

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cnt = 0;
    wrote = 0;
    n = int'(fifo_pkg::OFFSET_DEFAULT);
    m = int'(fifo_pkg::OFFSET_DEFAULT);
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  initial begin
    rst_i = 1'b1;
    cascade = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    failures = 0;
    samples_checked = 0;
    do_reset();
    wb(1'b0, fifo_pkg::REG_CMD, 32'h0, s);
    chk(32'(s[5:0]), 32'(st(0)));
    wb(1'b0, 4'hc, 32'h0, s);
    chk(s, 32'h0);
    ofs_rd(fifo_pkg::OFFSET_DEFAULT);
    ofs_rd(fifo_pkg::OFFSET_DEFAULT);
    cmd(fifo_pkg::CMD_OFS_WRITE, 18'h00005);
    cmd(fifo_pkg::CMD_OFS_WRITE, 18'h00007);
    wb(1'b0, fifo_pkg::REG_WDATA, 32'h0, s);
    chk(s, 32'h00000007);
    n = 5;
    m = 7;
    ofs_rd(14'h0005);
    ofs_rd(14'h0007);
    for (int i = 0; i < 4; i++) put(i);
    get(0);
    get(1);
    rt();
    put(4);
    for (int i = 0; i < 5; i++) get(i);
    rt();
    for (int i = 0; i < 5; i++) get(i);
    get(4);
    do_reset();
    for (int i = 0; i < D; i++) put(i);
    put(D);
    for (int i = 0; i < 3; i++) get(i);
    rt();
    // Second pass runs the read pointer past the last location
    for (int i = 0; i < D; i++) get(i);
    @(posedge clk_i);
    cascade <= 1'b1;
    rt();
    for (int i = 0; i <= D / 2; i++) put(i);
    get(0);
    finish_test();
  end
endmodule : tb_top
